// file: core/irq_bias_channel_regs.sv
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Clock error on serial interface sets status bit 7; bits 5..0 read zero.
// - Lock event of the PLL sets read-only status bit 6.
// - Bias field picks reference, reference times 1.096, or analog supply.
// - Full-scale field picks 2.75 V, 2.5 V or 1.375 V reference.
// - Channel type bit selects microphone at 0, line input at 1.
// - Source field selects differential, single-ended or PDM digital input.
// - Coupling bit selects AC or DC, for analog sources only.
// - Impedance field selects 2.5k, 10k or 20k for analog inputs.
// - Enhancer bit off disables both; on enables one per global select.
// - Readback bit hides masked sources in the latched status register.
// - Mask bits 7 and 6 reset to masked; writing zero unmasks.

module irq_bias_channel_regs
(
  input  wire logic       mclk_i,
  input  wire logic       arst_n_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       asi_clk_err_i,
  input  wire logic       pll_lock_i,
  input  wire logic       agc_select_i,
  output logic            mic_bias_ref_o,
  output logic            mic_bias_boost_o,
  output logic            mic_bias_supply_o,
  output logic            fs_2v75_o,
  output logic            fs_2v5_o,
  output logic            fs_1v375_o,
  output logic            ch1_line_input_o,
  output logic            ch1_src_diff_o,
  output logic            ch1_src_single_o,
  output logic            ch1_src_pdm_o,
  output logic            channel1_coupling_coupled_o,
  output logic            channel1_impedance_2k5_o,
  output logic            channel1_impedance_10k_o,
  output logic            channel1_impedance_20k_o,
  output logic            ch1_dre_en_o,
  output logic            ch1_agc_en_o
);

  typedef struct packed {
    logic mb_ref;
    logic mb_boost;
    logic mb_supply;
    logic fs_2v75;
    logic fs_2v5;
    logic fs_1v375;
    logic line;
    logic src_diff;
    logic src_single;
    logic src_pdm;
    logic dc;
    logic imp_2k5;
    logic imp_10k;
    logic imp_20k;
    logic dynamic_range_enhancer;
    logic automatic_gain_control;
  } drive_t;

  typedef struct packed {
    logic [7:0] irq_cfg;
    logic [7:0] irq_mask;
    logic [7:0] bias;
    logic [7:0] ch1;
    logic [7:0] rdata;
    logic       lock_q;
    drive_t     drive;
  } reg_state_t;

  reg_state_t state;
  reg_state_t next_state;
  logic [1:0] rst_sync;
  logic       rst_n;
  logic [1:0] shown_status;
  logic [7:0] status_byte;

  status_if sif ();

  // Only writable bits change, so reserved bits stay zero
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wdata, input logic [7:0] wmask);
    merge = (old & ~wmask) | (wdata & wmask);
  endfunction

  // ----------------------------------------------------------------
  // Reset release through two flops
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // Latched status and its readback view
  // ----------------------------------------------------------------
  // Clock error is a level, so it keeps re-setting while present
  assign sif.event_set  = {asi_clk_err_i, pll_lock_i & ~state.lock_q};
  assign sif.read_clear = reg_rd_i && (reg_addr_i == adc_ctrl_pkg::ADDR_LATCHED_STATUS);

  // Masked sources hidden only when the readback bit asks for it
  assign shown_status = sif.latched & ~({2{state.irq_cfg[adc_ctrl_pkg::LATCH_READBACK_BIT]}}
                        & state.irq_mask[adc_ctrl_pkg::STAT_CLK_ERR_BIT -: 2]);
  assign status_byte  = {shown_status, 6'h00};

  irq_status_latch u_latch
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .sif     (sif)
  );

  // ----------------------------------------------------------------
  // Register writes, readback and decoded controls
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state        = state;
    next_state.lock_q = pll_lock_i;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        adc_ctrl_pkg::ADDR_IRQ_CFG:
          next_state.irq_cfg = merge(state.irq_cfg, reg_wdata_i, adc_ctrl_pkg::WMASK_IRQ_CFG);
        adc_ctrl_pkg::ADDR_IRQ_MASK:
          next_state.irq_mask = merge(state.irq_mask, reg_wdata_i, adc_ctrl_pkg::WMASK_IRQ_MASK);
        adc_ctrl_pkg::ADDR_BIAS_FULLSCALE:
          next_state.bias = merge(state.bias, reg_wdata_i, adc_ctrl_pkg::WMASK_BIAS_FULLSCALE);
        adc_ctrl_pkg::ADDR_CH1_INPUT:
          next_state.ch1 = merge(state.ch1, reg_wdata_i, adc_ctrl_pkg::WMASK_CH1_INPUT);
        default:
          next_state.ch1 = state.ch1; // Status and unmapped writes dropped
      endcase
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        adc_ctrl_pkg::ADDR_IRQ_CFG:        next_state.rdata = state.irq_cfg;
        adc_ctrl_pkg::ADDR_IRQ_MASK:       next_state.rdata = state.irq_mask;
        adc_ctrl_pkg::ADDR_LATCHED_STATUS: next_state.rdata = status_byte;
        adc_ctrl_pkg::ADDR_BIAS_FULLSCALE: next_state.rdata = state.bias;
        adc_ctrl_pkg::ADDR_CH1_INPUT:      next_state.rdata = state.ch1;
        default:                           next_state.rdata = 8'h00;
      endcase
    end
    // Reserved codes drive no selection at all, the safest analog state
    next_state.drive.mb_ref    = next_state.bias[adc_ctrl_pkg::MIC_BIAS_LSB +: 3] == adc_ctrl_pkg::MIC_BIAS_REF;
    next_state.drive.mb_boost  = next_state.bias[adc_ctrl_pkg::MIC_BIAS_LSB +: 3] == adc_ctrl_pkg::MIC_BIAS_BOOST;
    next_state.drive.mb_supply = next_state.bias[adc_ctrl_pkg::MIC_BIAS_LSB +: 3] == adc_ctrl_pkg::MIC_BIAS_SUPPLY;
    next_state.drive.fs_2v75   = next_state.bias[adc_ctrl_pkg::FULL_SCALE_LSB +: 2] == adc_ctrl_pkg::FS_2V75;
    next_state.drive.fs_2v5    = next_state.bias[adc_ctrl_pkg::FULL_SCALE_LSB +: 2] == adc_ctrl_pkg::FS_2V5;
    next_state.drive.fs_1v375  = next_state.bias[adc_ctrl_pkg::FULL_SCALE_LSB +: 2] == adc_ctrl_pkg::FS_1V375;
    next_state.drive.line       = next_state.ch1[adc_ctrl_pkg::CH1_TYPE_BIT];
    next_state.drive.src_diff   = next_state.ch1[adc_ctrl_pkg::CH1_SOURCE_LSB +: 2] == adc_ctrl_pkg::SRC_DIFF;
    next_state.drive.src_single = next_state.ch1[adc_ctrl_pkg::CH1_SOURCE_LSB +: 2] == adc_ctrl_pkg::SRC_SINGLE;
    next_state.drive.src_pdm    = next_state.ch1[adc_ctrl_pkg::CH1_SOURCE_LSB +: 2] == adc_ctrl_pkg::SRC_PDM;
    // Coupling and impedance only mean something on an analog path
    next_state.drive.dc = next_state.ch1[adc_ctrl_pkg::CH1_COUPLING_BIT]
                          & (next_state.drive.src_diff | next_state.drive.src_single);
    next_state.drive.imp_2k5 = (next_state.drive.src_diff | next_state.drive.src_single)
                          & (next_state.ch1[adc_ctrl_pkg::CH1_IMPEDANCE_LSB +: 2] == adc_ctrl_pkg::IMP_2K5);
    next_state.drive.imp_10k = (next_state.drive.src_diff | next_state.drive.src_single)
                          & (next_state.ch1[adc_ctrl_pkg::CH1_IMPEDANCE_LSB +: 2] == adc_ctrl_pkg::IMP_10K);
    next_state.drive.imp_20k = (next_state.drive.src_diff | next_state.drive.src_single)
                          & (next_state.ch1[adc_ctrl_pkg::CH1_IMPEDANCE_LSB +: 2] == adc_ctrl_pkg::IMP_20K);
    next_state.drive.dynamic_range_enhancer = next_state.ch1[adc_ctrl_pkg::CH1_ENHANCER_BIT] & ~agc_select_i;
    next_state.drive.automatic_gain_control = next_state.ch1[adc_ctrl_pkg::CH1_ENHANCER_BIT] & agc_select_i;
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state          <= '0;
      state.irq_cfg  <= adc_ctrl_pkg::RST_IRQ_CFG;
      state.irq_mask <= adc_ctrl_pkg::RST_IRQ_MASK;
      state.bias     <= adc_ctrl_pkg::RST_BIAS_FULLSCALE;
      state.ch1      <= adc_ctrl_pkg::RST_CH1_INPUT;
      state.drive    <= adc_ctrl_pkg::RST_DRIVE; // Decode of all-zero fields
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  assign reg_rdata_o       = state.rdata;
  assign mic_bias_ref_o    = state.drive.mb_ref;
  assign mic_bias_boost_o  = state.drive.mb_boost;
  assign mic_bias_supply_o = state.drive.mb_supply;
  assign fs_2v75_o         = state.drive.fs_2v75;
  assign fs_2v5_o          = state.drive.fs_2v5;
  assign fs_1v375_o        = state.drive.fs_1v375;
  assign ch1_line_input_o  = state.drive.line;
  assign ch1_src_diff_o    = state.drive.src_diff;
  assign ch1_src_single_o  = state.drive.src_single;
  assign ch1_src_pdm_o     = state.drive.src_pdm;
  assign channel1_coupling_coupled_o  = state.drive.dc;
  assign channel1_impedance_2k5_o     = state.drive.imp_2k5;
  assign channel1_impedance_10k_o     = state.drive.imp_10k;
  assign channel1_impedance_20k_o     = state.drive.imp_20k;
  assign ch1_dre_en_o      = state.drive.dynamic_range_enhancer;
  assign ch1_agc_en_o      = state.drive.automatic_gain_control;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_status_read;
    reg_rd_i && reg_addr_i == adc_ctrl_pkg::ADDR_LATCHED_STATUS;
  endsequence

  sequence seq_status_shown;
    reg_rdata_o == $past(status_byte) && reg_rdata_o[5:0] == 6'h00;
  endsequence

  a_status_readback: assert property (@(posedge mclk_i) disable iff (!rst_n)
    seq_status_read |=> seq_status_shown)
    else $error("latched status readback wrong");

  a_masked_hidden: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (seq_status_read ##0 state.irq_cfg[2] && state.irq_mask[7]) |=> (reg_rdata_o[7] == 1'b0))
    else $error("masked clock error shown in readback");

  a_reserved_zero: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (reg_wr_i && reg_addr_i == adc_ctrl_pkg::ADDR_BIAS_FULLSCALE) |=> (state.bias[7] == 1'b0 && state.bias[3:2] == 2'h0))
    else $error("reserved bias bits took a write");

  a_mask_write: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (reg_wr_i && reg_addr_i == adc_ctrl_pkg::ADDR_IRQ_MASK) |=> (state.irq_mask == $past(reg_wdata_i)))
    else $error("mask register did not take write");

  a_bias_supply: assert property (@(posedge mclk_i) disable iff (!rst_n)
    mic_bias_supply_o == (state.bias[6:4] == 3'h6) && !(mic_bias_ref_o && mic_bias_boost_o))
    else $error("bias select decode wrong");

  a_fs_decode: assert property (@(posedge mclk_i) disable iff (!rst_n)
    fs_1v375_o == (state.bias[1:0] == 2'h2) && $onehot0({fs_2v75_o, fs_2v5_o, fs_1v375_o}))
    else $error("full-scale decode wrong");

  a_pdm_no_analog: assert property (@(posedge mclk_i) disable iff (!rst_n)
    ch1_src_pdm_o |-> !channel1_coupling_coupled_o && !channel1_impedance_2k5_o && !channel1_impedance_10k_o && !channel1_impedance_20k_o)
    else $error("analog setting active on digital source");

  a_enhancer_off: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (reg_wr_i && reg_addr_i == adc_ctrl_pkg::ADDR_CH1_INPUT && !reg_wdata_i[0]) |=> !ch1_dre_en_o && !ch1_agc_en_o)
    else $error("enhancer or gain control left on");

  a_line_type: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (reg_wr_i && reg_addr_i == adc_ctrl_pkg::ADDR_CH1_INPUT) |=> ch1_line_input_o == $past(reg_wdata_i[7]))
    else $error("input type not applied");

  a_source_sel: assert property (@(posedge mclk_i) disable iff (!rst_n)
    ch1_src_single_o == (state.ch1[6:5] == 2'h1) && ch1_src_pdm_o == (state.ch1[6:5] == 2'h2))
    else $error("source decode wrong");

  a_imp_sel: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (state.ch1[6:5] == 2'h0 && state.ch1[3:2] == 2'h2) |-> channel1_impedance_20k_o)
    else $error("impedance decode wrong");

  a_lock_event: assert property (@(posedge mclk_i) disable iff (!rst_n)
    ($rose(pll_lock_i) && !sif.read_clear) |=> sif.latched[0])
    else $error("lock event not latched");

  a_clear_persist: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (seq_status_read ##0 !asi_clk_err_i && !($rose(pll_lock_i))) |=> sif.latched == 2'h0)
    else $error("status not cleared by read");

endmodule // irq_bias_channel_regs

`default_nettype wire

// file: core/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the control port
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_CFG         = 8'h32;
  localparam logic [7:0] ADDR_IRQ_MASK        = 8'h33;
  localparam logic [7:0] ADDR_LATCHED_STATUS  = 8'h36;
  localparam logic [7:0] ADDR_BIAS_FULLSCALE  = 8'h3B;
  localparam logic [7:0] ADDR_CH1_INPUT       = 8'h3C;

  // ----------------------------------------------------------------
  // Reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_IRQ_CFG          = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK         = 8'hFF;
  localparam logic [7:0] RST_BIAS_FULLSCALE   = 8'h00;
  localparam logic [7:0] RST_CH1_INPUT        = 8'h00;
  localparam logic [1:0] RST_LATCHED          = 2'h0;
  // Decoded controls for all-zero fields: bias reference, 2.75 V, differential, 2.5k
  localparam logic [15:0] RST_DRIVE           = 16'h9110;
  localparam logic [7:0] WMASK_IRQ_CFG        = 8'h04;
  localparam logic [7:0] WMASK_IRQ_MASK       = 8'hFF;
  localparam logic [7:0] WMASK_BIAS_FULLSCALE = 8'h73;
  localparam logic [7:0] WMASK_CH1_INPUT      = 8'hFD;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAT_CLK_ERR_BIT   = 7;
  localparam int STAT_PLL_LOCK_BIT  = 6;
  localparam int LATCH_READBACK_BIT = 2;
  localparam int MIC_BIAS_LSB       = 4;
  localparam int FULL_SCALE_LSB     = 0;
  localparam int CH1_TYPE_BIT       = 7;
  localparam int CH1_SOURCE_LSB     = 5;
  localparam int CH1_COUPLING_BIT   = 4;
  localparam int CH1_IMPEDANCE_LSB  = 2;
  localparam int CH1_ENHANCER_BIT   = 0;

  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MIC_BIAS_REF    = 3'h0;
  localparam logic [2:0] MIC_BIAS_BOOST  = 3'h1;
  localparam logic [2:0] MIC_BIAS_SUPPLY = 3'h6;
  localparam logic [1:0] FS_2V75         = 2'h0;
  localparam logic [1:0] FS_2V5          = 2'h1;
  localparam logic [1:0] FS_1V375        = 2'h2;
  localparam logic [1:0] SRC_DIFF        = 2'h0;
  localparam logic [1:0] SRC_SINGLE      = 2'h1;
  localparam logic [1:0] SRC_PDM         = 2'h2;
  localparam logic [1:0] IMP_2K5         = 2'h0;
  localparam logic [1:0] IMP_10K         = 2'h1;
  localparam logic [1:0] IMP_20K         = 2'h2;

endpackage

// file: core/status_if.sv
`timescale 1ns/10ps
`default_nettype none

// Event sources, read-clear request and latched bits [1]=clock error, [0]=lock
interface status_if;
  logic [1:0] event_set;
  logic       read_clear;
  logic [1:0] latched;
  modport owner (input event_set, input read_clear, output latched);
  modport user  (output event_set, output read_clear, input latched);
endinterface

`default_nettype wire

// file: core/irq_status_latch.sv
`timescale 1ns/10ps
`default_nettype none

module irq_status_latch
(
  input  wire logic   mclk_i,
  input  wire logic   rst_n_i,
  status_if.owner     sif
);

  typedef struct packed {
    logic [1:0] latched;
  } latch_state_t;

  latch_state_t state;
  latch_state_t next_state;

  // ----------------------------------------------------------------
  // Sticky bits: a new event in the clearing cycle wins
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    if (sif.read_clear)
    begin
      next_state.latched = 2'h0;
    end
    next_state.latched = next_state.latched | sif.event_set;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state.latched <= adc_ctrl_pkg::RST_LATCHED;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign sif.latched = state.latched;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_event_sets_bit: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (sif.event_set != 2'h0) |=> ((sif.latched & $past(sif.event_set)) == $past(sif.event_set)))
    else $error("latched bit missed its event");

  a_read_clears_bits: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (sif.read_clear && sif.event_set == 2'h0) |=> (sif.latched == 2'h0))
    else $error("latched bits survived a read with no event");

  a_bits_held: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!sif.read_clear) |=> ((sif.latched & $past(sif.latched)) == $past(sif.latched)))
    else $error("latched bit dropped without a read");

endmodule // irq_status_latch

`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk_i;
  logic        arst_n_i;
  logic [7:0]  reg_addr_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_wdata_i;
  logic [7:0]  reg_rdata_o;
  logic        asi_clk_err_i;
  logic        pll_lock_i;
  logic        agc_select_i;
  wire  [15:0] dec;
  logic [7:0]  rv;
  logic [7:0]  c;
  int          mismatches;
  int          cmp_count;

  // ----------------------------------------------------------------
  // Device under test
  // ----------------------------------------------------------------
  irq_bias_channel_regs u_dut
  (
    .mclk_i            (mclk_i),
    .arst_n_i          (arst_n_i),
    .reg_addr_i        (reg_addr_i),
    .reg_wr_i          (reg_wr_i),
    .reg_rd_i          (reg_rd_i),
    .reg_wdata_i       (reg_wdata_i),
    .reg_rdata_o       (reg_rdata_o),
    .asi_clk_err_i     (asi_clk_err_i),
    .pll_lock_i        (pll_lock_i),
    .agc_select_i      (agc_select_i),
    .mic_bias_ref_o    (dec[15]),
    .mic_bias_boost_o  (dec[14]),
    .mic_bias_supply_o (dec[13]),
    .fs_2v75_o         (dec[12]),
    .fs_2v5_o          (dec[11]),
    .fs_1v375_o        (dec[10]),
    .ch1_line_input_o  (dec[9]),
    .ch1_src_diff_o    (dec[8]),
    .ch1_src_single_o  (dec[7]),
    .ch1_src_pdm_o     (dec[6]),
    .channel1_coupling_coupled_o  (dec[5]),
    .channel1_impedance_2k5_o     (dec[4]),
    .channel1_impedance_10k_o     (dec[3]),
    .channel1_impedance_20k_o     (dec[2]),
    .ch1_dre_en_o      (dec[1]),
    .ch1_agc_en_o      (dec[0])
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Expected decode; reserved codes select nothing
  function automatic logic [15:0] dec_exp(input logic [7:0] b, input logic [7:0] ch, input logic a);
    logic an;
    an = (ch[6:5] == 2'h0) || (ch[6:5] == 2'h1);
    return {b[6:4] == 3'h0, b[6:4] == 3'h1, b[6:4] == 3'h6,
            b[1:0] == 2'h0, b[1:0] == 2'h1, b[1:0] == 2'h2,
            ch[7], ch[6:5] == 2'h0, ch[6:5] == 2'h1, ch[6:5] == 2'h2,
            ch[4] & an, an & (ch[3:2] == 2'h0), an & (ch[3:2] == 2'h1), an & (ch[3:2] == 2'h2),
            ch[0] & ~a, ch[0] & a};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      mismatches++;
    end
  endtask

  // Write strobe is one cycle; sample a moment after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // One-cycle clock error event
  task automatic err_pulse();
    @(posedge mclk_i);
    asi_clk_err_i <= 1'b1;
    @(posedge mclk_i);
    asi_clk_err_i <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // Tests need about 1400 cycles; allow far more before giving up
  initial
  begin
    #100000;
    mismatches++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    mismatches = 0;
    cmp_count = 0;
    arst_n_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_wdata_i = 8'h00;
    asi_clk_err_i = 1'b0;
    pll_lock_i = 1'b0;
    agc_select_i = 1'b0;
    repeat (20) @(posedge mclk_i);
    chk(dec, dec_exp(8'h00, 8'h00, 1'b0));
    arst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    // Reset values
    rd(8'h36, rv);
    chk(rv, 8'h00);
    rd(8'h3B, rv);
    chk(rv, 8'h00);
    rd(8'h3C, rv);
    chk(rv, 8'h00);
    rd(8'h33, rv);
    chk(rv, 8'hFF);
    rd(8'h32, rv);
    chk(rv, 8'h00);
    rd(8'h50, rv);
    chk(rv, 8'h00);
    // Status is read-only
    wr(8'h36, 8'hFF);
    rd(8'h36, rv);
    chk(rv, 8'h00);
    // Every bias and full-scale code, reserved bits set on write
    for (int i = 0; i < 8; i++)
    begin
      c = {1'b1, i[2:0], 2'h3, i[1:0]};
      wr(8'h3B, c);
      chk(dec[15:10], dec_exp(c, 8'h00, 1'b0) >> 10);
      rd(8'h3B, rv);
      chk(rv, c & 8'h73);
    end
    // Every channel setting with the global select following bit 1
    for (int i = 0; i < 256; i++)
    begin
      c = i[7:0];
      @(posedge mclk_i);
      agc_select_i <= c[1];
      wr(8'h3C, c);
      chk(dec[9:0], dec_exp(8'h00, c, c[1]) & 16'h03FF);
      rd(8'h3C, rv);
      chk(rv, c & 8'hFD);
    end
    // Clock error latches, read clears it
    err_pulse();
    rd(8'h36, rv);
    chk(rv, 8'h80);
    rd(8'h36, rv);
    chk(rv, 8'h00);
    // Lock event is the rising edge only
    @(posedge mclk_i);
    pll_lock_i <= 1'b1;
    rd(8'h36, rv);
    chk(rv, 8'h40);
    rd(8'h36, rv);
    chk(rv, 8'h00);
    // Persisting clock error survives the read
    @(posedge mclk_i);
    asi_clk_err_i <= 1'b1;
    rd(8'h36, rv);
    chk(rv, 8'h80);
    rd(8'h36, rv);
    chk(rv, 8'h80);
    @(posedge mclk_i);
    asi_clk_err_i <= 1'b0;
    pll_lock_i <= 1'b0;
    rd(8'h36, rv);
    chk(rv, 8'h80);
    rd(8'h36, rv);
    chk(rv, 8'h00);
    // Masked sources hidden in readback mode
    wr(8'h32, 8'hFF);
    rd(8'h32, rv);
    chk(rv, 8'h04);
    err_pulse();
    rd(8'h36, rv);
    chk(rv, 8'h00);
    // Unmasking shows them again
    wr(8'h33, 8'h3F);
    rd(8'h33, rv);
    chk(rv, 8'h3F);
    err_pulse();
    @(posedge mclk_i);
    pll_lock_i <= 1'b1;
    rd(8'h36, rv);
    chk(rv, 8'hC0);
    wr(8'h33, 8'hBF);
    err_pulse();
    @(posedge mclk_i);
    pll_lock_i <= 1'b0;
    @(posedge mclk_i);
    pll_lock_i <= 1'b1;
    rd(8'h36, rv);
    chk(rv, 8'h40);
    end_of_test();
  end

endmodule // tb_top

`default_nettype wire
